// *** bench/testbench.sv ***
// Self-checking bench: bus tasks, arm and trigger event table, timer.
// Assumes rtl/ on the include path; tick shortened to 4 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "tms_defines.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  logic        i_mclk = 1'b0;     // 250 MHz clock
  logic        i_sys_rst = 1'b1;  // Reset, held 4 cycles
  logic        hsel = 1'b0;       // Bus select
  logic [31:0] haddr = 32'h0;     // Bus address
  logic [1:0]  htrans = 2'h0;     // Transfer type
  logic        hwrite = 1'b0;     // Write flag
  logic [31:0] hwdata = 32'h0;    // Write data
  logic        fire = 1'b0;       // Fire key level
  wire  [31:0] hrdata;            // Read data
  wire         hready, src, meas, arm_ind, start_of_test_line;
  wire  [3:0]  link;              // Link lines
  wire  [2:0]  state;             // Sequencer state
  int          miscompares = 0;
  int          checks_done = 0;
  int          n;
  logic [31:0] r;
  // Rows: arm cfg, front_panel_fire_key cfg, first go, event, second go
  logic [31:0] rows [12] = '{
    32'h0310_0011, 32'h0110_0021, 32'h0410_0031,
    32'h0510_0041, 32'h0610_0051, 32'h0710_0051,
    32'h1410_0100, 32'h1310_0000, 32'h0010_1031,
    32'h0011_1100, 32'h0000_1101, 32'h0070_0101};
  always #2 i_mclk = ~i_mclk;
  tms_sequencer #(.TICK_CYC(4)) u_tms_sequencer (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
    .i_link_in(link), .i_start_of_test_line(start_of_test_line), .i_front_panel_fire_key(fire),
    .i_auto_delay_done(1'b0), .o_arm_ind(arm_ind), .o_source_act(src),
    .o_measure_act(meas), .o_state(state));
  tms_far_side u_tms_far_side (
    .i_mclk(i_mclk), .o_link_in(link), .o_start_of_test_line(start_of_test_line));
  // One single-word transfer, held until ready is sampled
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
           output logic [31:0] q);
    @(posedge i_mclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge i_mclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  // Cycles to the next source pulse; above lim means none
  task wait_src(input int lim, output int c);
    c = 0;
    do begin
      @(posedge i_mclk);
      c++;
    end while (src !== 1'b1 && c <= lim);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog well past the expected run
  initial begin
    repeat (30000) @(posedge i_mclk);
    miscompares++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    rd_chk(`TMS_REG_ARM_CNT, 32'h0000_0001);
    rd_chk(`TMS_REG_FRONT_PANEL_FIRE_KEY_CFG, `TMS_RST_FRONT_PANEL_FIRE_KEY_CFG);
    rd_chk(`TMS_REG_DACTION, `TMS_RST_DACTION);
    rd_chk(32'h0000_0040, 32'h0000_0000);
    wr(`TMS_REG_ARM_CNT, 32'h0000_0002);
    wr(`TMS_REG_FRONT_PANEL_FIRE_KEY_CNT, 32'h0000_07D0);
    rd_chk(`TMS_REG_FRONT_PANEL_FIRE_KEY_CNT, 32'h0000_0001);
    wr(`TMS_REG_FRONT_PANEL_FIRE_KEY_CNT, 32'h0000_04E2);
    rd_chk(`TMS_REG_FRONT_PANEL_FIRE_KEY_CNT, 32'h0000_04E2);
    wr(`TMS_REG_FRONT_PANEL_FIRE_KEY_CNT, 32'h0000_0001);
    wr(`TMS_REG_ARM_CNT, 32'h0000_0001);
    $display("test registers done");
    wr(`TMS_REG_DACTION, 32'h0000_0002);
    wr(`TMS_REG_TDELAY, 32'h0000_000A);
    wr(`TMS_REG_CTRL, 32'h0000_0001);
    wait_src(80, n);
    `CHK(n >= 36 && n <= 52, 1'b1)
    `CHK(arm_ind, 1'b1)
    wr(`TMS_REG_CTRL, 32'h0000_0000);
    repeat (3) @(posedge i_mclk);
    `CHK({state, arm_ind}, 4'h0)
    wr(`TMS_REG_TDELAY, 32'h0000_0000);
    $display("test trigger delay done");
    foreach (rows[i]) begin
      r = rows[i];
      u_tms_far_side.sot_idle(r[7:4] != 4'h5);
      wr(`TMS_REG_ARM_CFG, {24'h0, r[31:24]});
      wr(`TMS_REG_FRONT_PANEL_FIRE_KEY_CFG, {20'h0, r[23:12]});
      wr(`TMS_REG_CTRL, 32'h0000_0001);
      wait_src(40, n);
      `CHK(n <= 40, r[8])
      // Watch for the source pulse while the event is still being driven
      fork
        wait_src(80, n);
        begin
          if (r[7:4] == 4'h1) fire <= 1'b1;
          if (r[7:4] == 4'h2) wr(`TMS_REG_CTRL, 32'h0000_0005);
          if (r[7:4] == 4'h3) u_tms_far_side.link_pulse(0);
          if (r[7:4] >= 4'h4) u_tms_far_side.sot_pulse;
        end
      join
      fire <= 1'b0;
      `CHK(n <= 80, r[0])
      wr(`TMS_REG_CTRL, 32'h0000_0003);
      repeat (3) @(posedge i_mclk);
      `CHK({state, arm_ind}, 4'h0)
      wr(`TMS_REG_CTRL, 32'h0000_0000);
    end
    $display("test event table done");
    wr(`TMS_REG_ARM_CFG, 32'h0000_0002);
    wr(`TMS_REG_TIMER, 32'h0000_001E);
    wr(`TMS_REG_ARM_CNT, 32'h0000_0002);
    wr(`TMS_REG_CTRL, 32'h0000_0001);
    wait_src(40, n);
    `CHK(n <= 40, 1'b1)
    wait_src(100, n);
    `CHK(n > 100, 1'b1)
    wait_src(100, n);
    `CHK(n <= 100, 1'b1)
    wait_src(40, n);
    `CHK(n <= 40, 1'b1)
    $display("test timer done");
    final_report;
  end
endmodule // testbench
`default_nettype wire

// *** bench/tms_far_side.sv ***
// Far side: other instruments on the link lines and the part handler.
// Assumes tasks are called from the bench in the i_mclk domain.
`timescale 1ns/1ps
`default_nettype none
module tms_far_side (
  input  wire logic       i_mclk,
  output var  logic [3:0] o_link_in,
  output var  logic       o_start_of_test_line
);
  // Pulled-up idle lines
  initial begin
    o_link_in = 4'hf;
    o_start_of_test_line = 1'b1;
  end
  // Falling-edge trigger, low then high four cycles each
  task link_pulse(input int line);
    @(posedge i_mclk);
    o_link_in[line] <= 1'b0;
    repeat (4) @(posedge i_mclk);
    o_link_in[line] <= 1'b1;
    repeat (4) @(posedge i_mclk);
  endtask
  // Handler settles its line before a sweep starts
  task sot_idle(input logic lvl);
    @(posedge i_mclk);
    o_start_of_test_line <= lvl;
    repeat (8) @(posedge i_mclk);
  endtask
  // One pulse per sweep start, never per point
  task sot_pulse;
    @(posedge i_mclk);
    o_start_of_test_line <= ~o_start_of_test_line;
    repeat (4) @(posedge i_mclk);
    o_start_of_test_line <= ~o_start_of_test_line;
    repeat (4) @(posedge i_mclk);
  endtask
endmodule // tms_far_side
`default_nettype wire

// *** bench/tms_seq_chk.sv ***
// Checker for the trigger model sequencer, watching its ports only.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module tms_seq_chk (
  input wire logic        i_mclk,
  input wire logic        i_sys_rst,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic [31:0] i_hwdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [3:0]  i_link_in,
  input wire logic        o_arm_ind,
  input wire logic        o_source_act,
  input wire logic        o_measure_act,
  input wire logic [2:0]  o_state
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------
  // Data phase of a control write
  // ----------------------------------
  logic ctrl_wr; // High while write data stands
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) ctrl_wr <= 1'b0;
    else ctrl_wr <= i_hsel & i_htrans[1] & i_hready & i_hwrite & (i_haddr == 32'h0000_0000);
  end
  a_arm_follows: assert property (o_arm_ind == (o_state != 3'h0))
    else $error("arm indicator out of step");
  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("slave stalled or gave error");
  a_halt_idles: assert property (ctrl_wr && i_hwdata[1] |-> ##[1:3] o_state == 3'h0)
    else $error("halt did not idle");
  a_meas_order: assert property ($rose(o_state == 3'h7) |-> $past(o_state) inside {3'h5, 3'h6})
    else $error("measure without delay first");
  a_meas_len: assert property ($rose(o_measure_act) |->
    (o_measure_act [*5] ##1 !o_measure_act) or (##[1:6] o_state == 3'h0))
    else $error("measure length wrong");
  a_src_single: assert property (o_source_act |=> !o_source_act)
    else $error("source pulse too long");
  a_idle_quiet: assert property ((o_state == 3'h0) [*3] |-> !o_source_act && !o_measure_act)
    else $error("action while idle");
  a_link_holds: assert property ((o_state == 3'h2 && i_link_in == 4'hf) [*4]
    |=> o_state inside {3'h2, 3'h0})
    else $error("source detector passed without link");
  // Main scenarios reached
  c_halt: cover property (ctrl_wr && i_hwdata[1]);
  c_meas: cover property ($rose(o_measure_act));
  c_link_wait: cover property ((o_state == 3'h2) [*4]);
endmodule // tms_seq_chk
bind tms_sequencer tms_seq_chk u_chk (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .i_hwdata(i_hwdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_link_in(i_link_in),
  .o_arm_ind(o_arm_ind), .o_source_act(o_source_act), .o_measure_act(o_measure_act),
  .o_state(o_state));
`default_nettype wire

// *** rtl/tms_defines.vh ***
// Constants for the trigger model sequencer: register offsets, fields, timing.
// Assumes a 250 MHz system clock and a single AHB-Lite slave port.
`ifndef TMS_DEFINES_VH
`define TMS_DEFINES_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define TMS_REG_CTRL      8'h00
`define TMS_REG_ARM_CFG   8'h04
`define TMS_REG_FRONT_PANEL_FIRE_KEY_CFG  8'h08
`define TMS_REG_ARM_CNT   8'h0C
`define TMS_REG_FRONT_PANEL_FIRE_KEY_CNT  8'h10
`define TMS_REG_TDELAY    8'h14
`define TMS_REG_DACTION   8'h18
`define TMS_REG_TIMER     8'h1C
`define TMS_REG_SOAK      8'h20
`define TMS_REG_AUTO_DLY  8'h24
`define TMS_REG_STATUS    8'h28
`define TMS_REG_PASSES    8'h2C

// ---------------------------------------------------------------
// Control register bits (write 1 pulses, except output on and multi mode)
// ---------------------------------------------------------------
`define TMS_CTRL_OUT_ON   0
`define TMS_CTRL_HALT     1
`define TMS_CTRL_BUS_TRG  2
`define TMS_CTRL_MULTI    3

// ---------------------------------------------------------------
// Arm events (ARM_CFG[2:0]), bypass once at bit 4, link line [9:8]
// ---------------------------------------------------------------
`define TMS_ARM_IMM       3'h0
`define TMS_ARM_BUS       3'h1
`define TMS_ARM_TIMER     3'h2
`define TMS_ARM_MANUAL    3'h3
`define TMS_ARM_LINK      3'h4
`define TMS_ARM_SOT_LO    3'h5
`define TMS_ARM_SOT_HI    3'h6
`define TMS_ARM_SOT_ANY   3'h7
`define TMS_CFG_BYPASS    4
// Trigger config: bit0 link source, bit4 bypass once, bits 8..10 enables
`define TMS_TCFG_LINK     0
`define TMS_TCFG_EN_SRC   8
`define TMS_TCFG_EN_DLY   9
`define TMS_TCFG_EN_MEAS  10

// ---------------------------------------------------------------
// Reset values (bench defaults), count limit and infinite arm code
// ---------------------------------------------------------------
`define TMS_RST_ARM_CFG   32'h0000_0000
`define TMS_RST_FRONT_PANEL_FIRE_KEY_CFG  32'h0000_0100
`define TMS_RST_COUNT     12'h001
`define TMS_RST_DACTION   32'h0000_0064
`define TMS_COUNT_MAX     12'h9C4
`define TMS_ARM_INFINITE  12'h000

// ---------------------------------------------------------------
// Timebase: 10 us ticks; counts derived from clock rate
// ---------------------------------------------------------------
`define TMS_CLK_HZ        250000000
`define TMS_TICK_NS       10000
`define TMS_TICK_CYC      ((`TMS_TICK_NS * (`TMS_CLK_HZ / 1000000)) / 1000)
`define TMS_TDELAY_MAX    32'h05F5_E0F6
`define TMS_DACTION_MAX   32'h3B9A_C99C
`define TMS_MEAS_CYC      16'h0004

`endif

// *** rtl/tms_sequencer.v ***
// Trigger model sequencer: idle, arm layer, trigger layer with
// source / delay / measure actions and an AHB-Lite register port.
// Assumes one 250 MHz clock; link and start-of-test pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "tms_defines.vh"

module tms_sequencer #(
  parameter TICK_CYC = `TMS_TICK_CYC        // Cycles per timebase tick
) (
  input  wire        i_mclk,               // System clock
  input  wire        i_sys_rst,            // Async reset, active high
  input  wire        i_hsel,               // AHB select
  input  wire [31:0] i_haddr,              // AHB address
  input  wire [1:0]  i_htrans,             // AHB transfer type
  input  wire        i_hwrite,             // AHB write
  input  wire [2:0]  i_hsize,              // AHB size
  input  wire [31:0] i_hwdata,             // AHB write data
  input  wire        i_hready,             // AHB bus ready
  output reg  [31:0] o_hrdata,             // AHB read data
  output reg         o_hreadyout,          // AHB slave ready
  output reg         o_hresp,              // AHB response
  input  wire [3:0]  i_link_in,            // Trigger link lines, low pulse
  input  wire        i_start_of_test_line, // Handler start-of-test line
  input  wire        i_front_panel_fire_key, // Fire key press, sync level
  input  wire        i_auto_delay_done,    // Unused hook kept low by system
  output reg         o_arm_ind,            // Arm indicator
  output reg         o_source_act,         // Source action pulse
  output reg         o_measure_act,        // Measure action level
  output reg  [2:0]  o_state               // Sequencer state
);

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;          // Output off or halted
  localparam [2:0] S_ARM  = 3'h1;          // Arm event detector
  localparam [2:0] S_TSRC = 3'h2;          // Source detector
  localparam [2:0] S_TDLY = 3'h3;          // Trigger delay
  localparam [2:0] S_DDET = 3'h4;          // Delay detector
  localparam [2:0] S_DACT = 3'h5;          // Delay action
  localparam [2:0] S_MDET = 3'h6;          // Measure detector
  localparam [2:0] S_MACT = 3'h7;          // Measure action

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg        out_on;                       // Output enabled
  reg        multi_mode;                   // Multiple range-change mode
  reg [31:0] arm_cfg;                      // Arm event, bypass, line
  reg [31:0] front_panel_fire_key_cfg;                     // Trigger source, enables
  reg [11:0] arm_cnt;                      // Arm count, 0 infinite
  reg [11:0] front_panel_fire_key_cnt;                     // Trigger count
  reg [31:0] tdelay;                       // Trigger delay in ticks
  reg [31:0] daction;                      // Delay action in ticks
  reg [31:0] timer_iv;                     // Arm timer interval in ticks
  reg [31:0] soak;                         // Soak time in ticks
  reg [31:0] auto_dly;                     // Auto delay value in ticks
  reg        auto_en;                      // Auto delay enabled
  reg        bus_trg;                      // Bus trigger pulse
  reg        halt;                         // Halt pulse
  reg        out_on_rise;                  // Output turned on pulse

  // AHB address-phase capture
  reg        wr_pend;                      // Write data phase pending
  reg [7:0]  wr_addr;                      // Latched write offset

  // Sequencer state
  reg [2:0]  state;                        // Current state
  reg [11:0] arm_done;                     // Arm passes done
  reg [11:0] front_panel_fire_key_done;                    // Trigger passes done
  reg [31:0] wait_ticks;                   // Remaining ticks in a wait
  reg [15:0] tick_div;                     // Timebase divider
  reg        tick;                         // One-cycle tick enable
  reg        first_arm;                    // First arm pass since output on or arm layer restart
  reg        arm_byp_used;                 // Arm bypass already spent
  reg        src_byp_used;                 // Source bypass already spent
  reg        first_sdm;                    // First delay action since output on
  reg [31:0] timer_cnt;                    // Arm interval timer
  reg [15:0] meas_cnt;                     // Measure action length
  reg [31:0] passes;                       // Total completed passes

  // Pin synchronisers and edge detect
  reg [3:0]  link_s1;                      // Link first stage
  reg [3:0]  link_s2;                      // Link second stage
  reg [3:0]  link_s3;                      // Link previous sample
  reg        sot_s1;                       // Start-of-test first stage
  reg        sot_s2;                       // Start-of-test second stage
  reg        sot_s3;                       // Start-of-test previous

  wire [3:0] link_fall = link_s3 & ~link_s2;   // Falling edge per line
  wire       sot_fall  = sot_s3 & ~sot_s2;     // Low pulse start
  wire       sot_rise  = ~sot_s3 & sot_s2;     // High pulse start
  wire       link_ev   = link_fall[arm_cfg[9:8]]; // Selected link line

  wire [2:0] arm_sel   = arm_cfg[2:0];
  wire       trg_link  = front_panel_fire_key_cfg[`TMS_TCFG_LINK];

  // ---------------------------------------------------------------
  // Synchronisers and timebase divider
  // ---------------------------------------------------------------
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      link_s1  <= 4'hF;
      link_s2  <= 4'hF;
      link_s3  <= 4'hF;
      // Idle high like the pulled-up line: no false edge after reset
      sot_s1   <= 1'b1;
      sot_s2   <= 1'b1;
      sot_s3   <= 1'b1;
      tick_div <= 16'h0000;
      tick     <= 1'b0;
    end else begin
      link_s1 <= i_link_in;
      link_s2 <= link_s1;
      link_s3 <= link_s2;
      sot_s1  <= i_start_of_test_line;
      sot_s2  <= sot_s1;
      sot_s3  <= sot_s2;
      // Tick every TICK_CYC cycles
      if (tick_div == TICK_CYC[15:0] - 16'h0001) begin
        tick_div <= 16'h0000;
        tick     <= 1'b1;
      end else begin
        tick_div <= tick_div + 16'h0001;
        tick     <= 1'b0;
      end
    end
  end

  // Arm event detection by selected event
  function arm_event;
    input [2:0] sel;
    input       first;
    input       tdone;
    begin
      case (sel)
        `TMS_ARM_IMM:     arm_event = 1'b1;
        `TMS_ARM_BUS:     arm_event = bus_trg;
        `TMS_ARM_TIMER:   arm_event = first | tdone;
        `TMS_ARM_MANUAL:  arm_event = i_front_panel_fire_key;
        `TMS_ARM_LINK:    arm_event = link_ev;
        `TMS_ARM_SOT_LO:  arm_event = sot_fall;
        `TMS_ARM_SOT_HI:  arm_event = sot_rise;
        default:          arm_event = sot_fall | sot_rise;
      endcase
    end
  endfunction

  // Trigger detector: immediate passes, link waits only when enabled
  function front_panel_fire_key_event;
    input en;
    begin
      front_panel_fire_key_event = ~trg_link | ~en | link_ev;
    end
  endfunction

  // Bypass only valid for link and start-of-test arm events
  wire arm_byp_ok = arm_cfg[`TMS_CFG_BYPASS] & ~arm_byp_used & first_arm &
                    (arm_sel >= `TMS_ARM_LINK);
  wire src_byp_ok = front_panel_fire_key_cfg[`TMS_CFG_BYPASS] & trg_link & ~src_byp_used;
  wire timer_done = (timer_cnt == 32'h0000_0000);
  wire [31:0] dly_load = first_sdm & multi_mode ? soak :
                         auto_en ? auto_dly : daction;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state        <= S_IDLE;
      arm_done     <= 12'h000;
      front_panel_fire_key_done    <= 12'h000;
      wait_ticks   <= 32'h0000_0000;
      first_arm    <= 1'b0;
      arm_byp_used <= 1'b0;
      src_byp_used <= 1'b0;
      first_sdm    <= 1'b0;
      timer_cnt    <= 32'h0000_0000;
      meas_cnt     <= 16'h0000;
      passes       <= 32'h0000_0000;
    end else if (halt | ~out_on) begin
      state        <= S_IDLE;
      arm_byp_used <= 1'b0;
      src_byp_used <= 1'b0;
      timer_cnt    <= 32'h0000_0000;
    end else begin
      // Interval timer counts down in ticks
      if (tick && !timer_done)
        timer_cnt <= timer_cnt - 32'h0000_0001;
      case (state)
        S_IDLE: begin
          if (out_on_rise) begin
            state     <= S_ARM;
            arm_done  <= 12'h000;
            first_arm <= 1'b1;
            first_sdm <= 1'b1;
          end
        end
        S_ARM: begin
          // Stall until event or bypass
          if (arm_byp_ok || arm_event(arm_sel, first_arm, timer_done)) begin
            if (arm_byp_ok)
              arm_byp_used <= 1'b1;
            first_arm  <= 1'b0;
            timer_cnt  <= timer_iv;
            front_panel_fire_key_done  <= 12'h000;
            state      <= S_TSRC;
          end
        end
        S_TSRC: begin
          if (src_byp_ok || front_panel_fire_key_event(front_panel_fire_key_cfg[`TMS_TCFG_EN_SRC])) begin
            if (src_byp_ok)
              src_byp_used <= 1'b1;
            wait_ticks <= tdelay;
            state      <= S_TDLY;
          end
        end
        S_TDLY: begin
          if (wait_ticks == 32'h0000_0000)
            state <= S_DDET;                 // source fires here
          else if (tick)
            wait_ticks <= wait_ticks - 32'h0000_0001;
        end
        S_DDET: begin
          if (front_panel_fire_key_event(front_panel_fire_key_cfg[`TMS_TCFG_EN_DLY])) begin
            wait_ticks <= dly_load;
            first_sdm  <= 1'b0;
            state      <= S_DACT;
          end
        end
        S_DACT: begin
          if (wait_ticks == 32'h0000_0000)
            state <= S_MDET;
          else if (tick)
            wait_ticks <= wait_ticks - 32'h0000_0001;
        end
        S_MDET: begin
          if (front_panel_fire_key_event(front_panel_fire_key_cfg[`TMS_TCFG_EN_MEAS])) begin
            meas_cnt <= `TMS_MEAS_CYC;
            state    <= S_MACT;
          end
        end
        S_MACT: begin
          if (meas_cnt != 16'h0000)
            meas_cnt <= meas_cnt - 16'h0001;
          else begin
            passes <= passes + 32'h0000_0001;
            // Trigger count then arm count
            if (front_panel_fire_key_done + 12'h001 < front_panel_fire_key_cnt) begin
              front_panel_fire_key_done <= front_panel_fire_key_done + 12'h001;
              state     <= S_TSRC;
            end else if (arm_cnt == `TMS_ARM_INFINITE ||
                         arm_done + 12'h001 < arm_cnt) begin
              arm_done <= arm_done + 12'h001;
              state    <= S_ARM;
            end else begin
              // Leaving arm layer: timer reset, run loops again
              arm_done  <= 12'h000;
              timer_cnt <= 32'h0000_0000;
              first_arm <= 1'b1;
              state     <= S_ARM;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs from flip-flops
  // ---------------------------------------------------------------
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_arm_ind     <= 1'b0;
      o_source_act  <= 1'b0;
      o_measure_act <= 1'b0;
      o_state       <= S_IDLE;
    end else begin
      o_arm_ind     <= (state != S_IDLE);
      o_source_act  <= (state == S_TDLY) && (wait_ticks == 32'h0000_0000);
      o_measure_act <= (state == S_MACT);
      o_state       <= state;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ---------------------------------------------------------------
  wire        ahb_go = i_hsel & i_htrans[1] & i_hready;
  wire [31:0] wd     = i_hwdata;
  // Count limit against the other count
  wire [23:0] prod_arm  = wd[11:0] * front_panel_fire_key_cnt;
  wire [23:0] prod_front_panel_fire_key = arm_cnt * wd[11:0];

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h00;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      out_on      <= 1'b0;
      out_on_rise <= 1'b0;
      multi_mode  <= 1'b0;
      halt        <= 1'b0;
      bus_trg     <= 1'b0;
      arm_cfg     <= `TMS_RST_ARM_CFG;
      front_panel_fire_key_cfg    <= `TMS_RST_FRONT_PANEL_FIRE_KEY_CFG;
      arm_cnt     <= `TMS_RST_COUNT;
      front_panel_fire_key_cnt    <= `TMS_RST_COUNT;
      tdelay      <= 32'h0000_0000;
      daction     <= `TMS_RST_DACTION;
      timer_iv    <= 32'h0000_0000;
      soak        <= 32'h0000_0000;
      auto_dly    <= 32'h0000_0000;
      auto_en     <= 1'b0;
    end else begin
      halt        <= 1'b0;
      bus_trg     <= 1'b0;
      out_on_rise <= 1'b0;
      wr_pend     <= ahb_go & i_hwrite;
      if (ahb_go)
        wr_addr <= i_haddr[7:0];
      // Read data prepared for the data phase
      if (ahb_go && !i_hwrite) begin
        case (i_haddr[7:0])
          `TMS_REG_CTRL:     o_hrdata <= {28'h0, multi_mode, 2'b00, out_on};
          `TMS_REG_ARM_CFG:  o_hrdata <= arm_cfg;
          `TMS_REG_FRONT_PANEL_FIRE_KEY_CFG: o_hrdata <= front_panel_fire_key_cfg;
          `TMS_REG_ARM_CNT:  o_hrdata <= {20'h0, arm_cnt};
          `TMS_REG_FRONT_PANEL_FIRE_KEY_CNT: o_hrdata <= {20'h0, front_panel_fire_key_cnt};
          `TMS_REG_TDELAY:   o_hrdata <= tdelay;
          `TMS_REG_DACTION:  o_hrdata <= daction;
          `TMS_REG_TIMER:    o_hrdata <= timer_iv;
          `TMS_REG_SOAK:     o_hrdata <= soak;
          `TMS_REG_AUTO_DLY: o_hrdata <= {auto_en, auto_dly[30:0]};
          `TMS_REG_STATUS:   o_hrdata <= {16'h0000, front_panel_fire_key_done, state, 1'b0};
          `TMS_REG_PASSES:   o_hrdata <= passes;
          default:           o_hrdata <= 32'h0000_0000;
        endcase
      end
      if (wr_pend) begin
        case (wr_addr)
          `TMS_REG_CTRL: begin
            out_on_rise <= wd[`TMS_CTRL_OUT_ON] & ~out_on;
            out_on      <= wd[`TMS_CTRL_OUT_ON];
            halt        <= wd[`TMS_CTRL_HALT];
            bus_trg     <= wd[`TMS_CTRL_BUS_TRG];
            multi_mode  <= wd[`TMS_CTRL_MULTI];
          end
          `TMS_REG_ARM_CFG:  arm_cfg  <= wd & 32'h0000_0317;
          `TMS_REG_FRONT_PANEL_FIRE_KEY_CFG: front_panel_fire_key_cfg <= wd & 32'h0000_0711;
          `TMS_REG_ARM_CNT:
            if (wd[11:0] == `TMS_ARM_INFINITE || prod_arm <= {12'h0, `TMS_COUNT_MAX})
              arm_cnt <= wd[11:0];
          `TMS_REG_FRONT_PANEL_FIRE_KEY_CNT:
            if (wd[11:0] != 12'h000 && (arm_cnt == `TMS_ARM_INFINITE ?
                wd[11:0] <= `TMS_COUNT_MAX : prod_front_panel_fire_key <= {12'h0, `TMS_COUNT_MAX}))
              front_panel_fire_key_cnt <= wd[11:0];
          `TMS_REG_TDELAY:
            if (wd <= `TMS_TDELAY_MAX) tdelay <= wd;
          `TMS_REG_DACTION:
            if (wd <= `TMS_DACTION_MAX) daction <= wd;
          `TMS_REG_TIMER:    timer_iv <= wd;
          `TMS_REG_SOAK:     soak     <= wd;
          `TMS_REG_AUTO_DLY: begin
            auto_en  <= wd[31];
            auto_dly <= {1'b0, wd[30:0]};
          end
          default: ;
        endcase
      end
    end
  end

endmodule // tms_sequencer
`default_nettype wire
